// File: hw/shs_pkg.sv
package shs_pkg;

    localparam int PAY_BITS = 64;
    localparam int BLK_PER_MB = 32;
    localparam int IDX_W = 5;
    localparam int CRC_W = 12;
    localparam logic [IDX_W-1:0] IDX_LAST = 5'h1f;
    localparam logic [IDX_W-1:0] IDX_CRC_DONE = 5'h0e;
    localparam logic [1:0] HDR_ONE = 2'h1;
    localparam logic [1:0] HDR_ZERO = 2'h2;
    localparam logic [CRC_W-1:0] CRC_POLY_KOOP = 12'h987;
    localparam logic [CRC_W-1:0] CRC_FB_MASK = {CRC_POLY_KOOP[10:0], 1'b1};
    localparam logic [CRC_W-1:0] CRC_INIT = 12'h000;
    localparam int POS_EXTENDED_GROUP_END_FLAG = 22;
    // Stream word indexed by position: fixed ones, end flag, end pattern.
    localparam logic [31:0] CRC_TMPL = 32'h80e8_8888;
    localparam logic [31:0] CRC_PILOT_MASK = 32'hf8e8_8888;
    localparam logic [31:0] FEC_PILOT_MASK = 32'hf840_0000;
    localparam logic [31:0] FEC_PILOT_VAL = 32'h8040_0000;
    // Receiver thresholds.
    localparam int FEC_HITS = 4;
    localparam int HDR_BAD_LIM = 4;
    localparam int MB_ERR_LIM = 2;
    localparam int CNT_W = 3;

    // Stream position of CRC bit i: three bits, then a fixed one.
    function automatic int crc_pos(input int i);
        return (11 - i) + (11 - i) / 3;
    endfunction

    // Serial CRC over one block, first transmitted bit is bit 63.
    function automatic logic [CRC_W-1:0] crc_step(
        input logic [CRC_W-1:0] c,
        input logic [PAY_BITS-1:0] d
    );
        logic [CRC_W-1:0] r;
        logic fb;
        r = c;
        for (int k = PAY_BITS - 1; k >= 0; k--)
        begin
            fb = d[k] ^ r[CRC_W-1];
            r = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_FB_MASK : CRC_INIT);
        end
        return r;
    endfunction

    // Whole transmit stream word for a given parity.
    function automatic logic [31:0] stream_word(input logic [CRC_W-1:0] p);
        logic [31:0] w;
        w = CRC_TMPL;
        for (int i = 0; i < CRC_W; i++)
        begin
            w[crc_pos(i)] = p[i];
        end
        return w;
    endfunction

endpackage

// File: hw/shs_link_if.sv
`timescale 1ns/1ps
// One 66-bit block per cycle in which blk_valid is high.
// blk_hdr[1] is the first transmitted header bit.
interface shs_link_if;
    logic blk_valid;
    logic [1:0] blk_hdr;
    logic [63:0] blk_pay;

    modport tx (output blk_valid, output blk_hdr, output blk_pay);
    modport rx (input blk_valid, input blk_hdr, input blk_pay);
endinterface

// File: hw/shs_tx.sv
`timescale 1ns/1ps
module shs_tx
    import shs_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Alignment strobe from the board, not on this clock.
    input wire logic sysref,
    // Scrambled payload, one block per cycle when valid.
    input wire logic pay_valid,
    input wire logic [PAY_BITS-1:0] pay_data,
    // Status toward the user side.
    output logic mb_start,
    output logic local_extended_group_clock_slip,
    output logic [IDX_W-1:0] blk_idx,
    output logic [CRC_W-1:0] parity_sent,
    // Link toward the receiver.
    shs_link_if.tx link
);

    logic sref_s1_q;
    logic sref_s2_q;
    logic sref_s3_q;
    logic sref_lvl_q;
    logic sref_lvl_d;
    logic sref_edge;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] idx_d;
    logic [IDX_W-1:0] cur_idx;
    logic [CRC_W-1:0] crc_q;
    logic [CRC_W-1:0] crc_d;
    logic [CRC_W-1:0] cur_crc;
    logic [CRC_W-1:0] crc_next;
    logic [CRC_W-1:0] par_q;
    logic [CRC_W-1:0] par_d;
    logic [31:0] word;
    logic vld_q;
    logic vld_d;
    logic [1:0] hdr_q;
    logic [1:0] hdr_d;
    logic [PAY_BITS-1:0] pay_q;
    logic [PAY_BITS-1:0] pay_d;
    logic mbs_q;
    logic mbs_d;
    logic slip_q;
    logic slip_d;

    // Strobe synchroniser; the first stage feeds only the second.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sref_s1_q <= 1'b0;
            sref_s2_q <= 1'b0;
            sref_s3_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sref_s1_q <= sysref;
            sref_s2_q <= sref_s1_q;
            sref_s3_q <= sref_s2_q;
        end
    end

    // A level change counts only once stages two and three agree.
    always_comb
    begin
        sref_lvl_d = (sref_s2_q == sref_s3_q) ? sref_s2_q : sref_lvl_q;
        sref_edge = sref_s2_q & sref_s3_q & ~sref_lvl_q;
    end

    // Block counter, CRC and header encoding.
    always_comb
    begin
        // A strobe restarts the group clock at this very block.
        cur_idx = sref_edge ? '0 : idx_q;
        cur_crc = sref_edge ? CRC_INIT : crc_q;
        crc_next = crc_step(cur_crc, pay_data);
        word = stream_word(par_q);
        word[POS_EXTENDED_GROUP_END_FLAG] = 1'b1;
        idx_d = cur_idx;
        crc_d = cur_crc;
        par_d = par_q;
        vld_d = 1'b0;
        hdr_d = hdr_q;
        pay_d = pay_q;
        mbs_d = 1'b0;
        slip_d = sref_edge && (idx_q != '0);
        if (pay_valid)
        begin
            vld_d = 1'b1;
            pay_d = pay_data;
            // Bit of the stream for this block goes into its header.
            hdr_d = word[cur_idx] ? HDR_ONE : HDR_ZERO;
            mbs_d = (cur_idx == '0);
            if (cur_idx == IDX_LAST)
            begin
                // Parity of this group rides in the next one.
                par_d = crc_next;
                crc_d = CRC_INIT;
                idx_d = '0;
            end
            else
            begin
                crc_d = crc_next;
                idx_d = cur_idx + 5'h01;
            end
        end
    end

    // Only the CRC-12 layout exists here; no other stream form is built.
    // A partial group after a strobe leaves the previous parity in place.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sref_lvl_q <= 1'b0;
            idx_q <= '0;
            crc_q <= CRC_INIT;
            par_q <= CRC_INIT;
            vld_q <= 1'b0;
            hdr_q <= HDR_ZERO;
            pay_q <= '0;
            mbs_q <= 1'b0;
            slip_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sref_lvl_q <= sref_lvl_d;
            idx_q <= idx_d;
            crc_q <= crc_d;
            par_q <= par_d;
            vld_q <= vld_d;
            hdr_q <= hdr_d;
            pay_q <= pay_d;
            mbs_q <= mbs_d;
            slip_q <= slip_d;
        end
    end

    // All outputs come straight from registers.
    assign link.blk_valid = vld_q;
    assign link.blk_hdr = hdr_q;
    assign link.blk_pay = pay_q;
    assign mb_start = mbs_q;
    assign local_extended_group_clock_slip = slip_q;
    assign blk_idx = idx_q;
    assign parity_sent = par_q;

endmodule

// File: hw/shs_rx.sv
`timescale 1ns/1ps
module shs_rx
    import shs_pkg::*;
#(
    parameter int HITS_NEED = FEC_HITS,
    parameter int BAD_LIM = HDR_BAD_LIM,
    parameter int ERR_LIM = MB_ERR_LIM
)
(
    // Clock, reset and freeze.
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Alignment strobe from the board, not on this clock.
    input wire logic sysref,
    // Stream form selection: high for FEC framing.
    input wire logic fec_mode,
    // Link from the transmitter.
    shs_link_if.rx link,
    // Recovered payload and status.
    output logic out_valid,
    output logic [PAY_BITS-1:0] out_data,
    output logic mb_locked,
    output logic [IDX_W-1:0] blk_idx,
    output logic hdr_bad,
    output logic mb_err,
    output logic crc_err,
    output logic realign_req
);

    typedef enum logic {SHS_HUNT, SHS_LOCK} shs_state_t;

    shs_state_t st_q;
    shs_state_t st_d;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic lvl_d;
    logic edge_s;
    logic [31:0] sh_q;
    logic [31:0] sh_d;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] idx_d;
    logic [CRC_W-1:0] crc_q;
    logic [CRC_W-1:0] crc_d;
    logic [CRC_W-1:0] crc_n;
    logic [CRC_W-1:0] exp_q;
    logic [CRC_W-1:0] exp_d;
    logic [CRC_W-1:0] got;
    logic exv_q;
    logic exv_d;
    logic [CNT_W-1:0] hits_q;
    logic [CNT_W-1:0] hits_d;
    logic [CNT_W-1:0] bad_q;
    logic [CNT_W-1:0] bad_d;
    logic [CNT_W-1:0] err_q;
    logic [CNT_W-1:0] err_d;
    logic pilot_ok;
    logic [CNT_W-1:0] need;
    logic ov_q;
    logic ov_d;
    logic [PAY_BITS-1:0] od_q;
    logic [PAY_BITS-1:0] od_d;
    logic hb_q;
    logic hb_d;
    logic me_q;
    logic me_d;
    logic ce_q;
    logic ce_d;
    logic rr_q;
    logic rr_d;

    // Strobe synchroniser; the first stage feeds only the second.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else if (clk_en)
        begin
            s1_q <= sysref;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Framing, lock tracking and CRC check.
    always_comb
    begin
        lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
        edge_s = s2_q & s3_q & ~lvl_q;
        // Position p of the stream ends up in sh[p] after 32 shifts.
        sh_d = {link.blk_hdr == HDR_ONE, sh_q[31:1]};
        pilot_ok = fec_mode
            ? ((sh_d & FEC_PILOT_MASK) == FEC_PILOT_VAL)
            : ((sh_d & CRC_PILOT_MASK) == CRC_TMPL);
        need = fec_mode ? CNT_W'(HITS_NEED) : 3'h1;
        crc_n = crc_step(crc_q, link.blk_pay);
        for (int i = 0; i < CRC_W; i++)
        begin
            got[i] = sh_d[17 + crc_pos(i)];
        end
        st_d = st_q;
        idx_d = idx_q;
        crc_d = crc_q;
        exp_d = exp_q;
        exv_d = exv_q;
        hits_d = hits_q;
        bad_d = bad_q;
        err_d = err_q;
        rr_d = rr_q;
        ov_d = 1'b0;
        od_d = od_q;
        hb_d = 1'b0;
        me_d = 1'b0;
        ce_d = 1'b0;
        if (!link.blk_valid)
        begin
            sh_d = sh_q;
        end
        else
        begin
            idx_d = idx_q + 5'h01;
            // Equal header bits hint at a slipped block boundary.
            if (link.blk_hdr[1] == link.blk_hdr[0])
            begin
                hb_d = 1'b1;
                bad_d = (bad_q == '1) ? bad_q : bad_q + 3'h1;
            end
            if (bad_d >= CNT_W'(BAD_LIM))
            begin
                rr_d = 1'b1;
                st_d = SHS_HUNT;
                hits_d = '0;
            end
            else if (st_q == SHS_HUNT)
            begin
                if (pilot_ok)
                begin
                    // A repeat counts only a whole number of groups later.
                    hits_d = (idx_q == IDX_LAST && hits_q != '0)
                        ? hits_q + 3'h1 : 3'h1;
                    idx_d = '0;
                    if (hits_d >= need)
                    begin
                        st_d = SHS_LOCK;
                        crc_d = CRC_INIT;
                        exv_d = 1'b0;
                        err_d = '0;
                    end
                end
            end
            else
            begin
                ov_d = 1'b1;
                od_d = link.blk_pay;
                crc_d = crc_n;
                if (idx_q == IDX_CRC_DONE && exv_q && !fec_mode
                    && got != exp_q)
                begin
                    ce_d = 1'b1;
                end
                if (idx_q == IDX_LAST)
                begin
                    exp_d = crc_n;
                    exv_d = 1'b1;
                    crc_d = CRC_INIT;
                    bad_d = '0;
                    if (!pilot_ok)
                    begin
                        me_d = 1'b1;
                        err_d = err_q + 3'h1;
                        if (err_d >= CNT_W'(ERR_LIM))
                        begin
                            st_d = SHS_HUNT;
                            hits_d = '0;
                        end
                    end
                    else
                    begin
                        err_d = '0;
                    end
                end
            end
        end
        // A strobe resets the local group clock and restarts the search.
        if (edge_s)
        begin
            rr_d = 1'b0;
            bad_d = '0;
            hits_d = '0;
            idx_d = '0;
            st_d = SHS_HUNT;
        end
    end

    // The check fires at block 14 of the next group, 46 blocks on.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= SHS_HUNT;
            lvl_q <= 1'b0;
            sh_q <= '0;
            idx_q <= '0;
            crc_q <= CRC_INIT;
            exp_q <= CRC_INIT;
            exv_q <= 1'b0;
            hits_q <= '0;
            bad_q <= '0;
            err_q <= '0;
            rr_q <= 1'b0;
            ov_q <= 1'b0;
            od_q <= '0;
            hb_q <= 1'b0;
            me_q <= 1'b0;
            ce_q <= 1'b0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
            lvl_q <= lvl_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            crc_q <= crc_d;
            exp_q <= exp_d;
            exv_q <= exv_d;
            hits_q <= hits_d;
            bad_q <= bad_d;
            err_q <= err_d;
            rr_q <= rr_d;
            ov_q <= ov_d;
            od_q <= od_d;
            hb_q <= hb_d;
            me_q <= me_d;
            ce_q <= ce_d;
        end
    end

    assign out_valid = ov_q;
    assign out_data = od_q;
    assign mb_locked = (st_q == SHS_LOCK);
    assign blk_idx = idx_q;
    assign hdr_bad = hb_q;
    assign mb_err = me_q;
    assign crc_err = ce_q;
    assign realign_req = rr_q;

endmodule

// File: sim/shs_monitor.sv
`timescale 1ns/1ps
module shs_monitor
(
    // Clock and reset.
    input wire logic clock,
    input wire logic sys_rst,
    // Link signals between the two ends.
    input wire logic blk_valid,
    input wire logic [1:0] blk_hdr,
    input wire logic [63:0] blk_pay
);
    logic [4:0] idx_q, idx_d;
    logic [31:0] sw_q, sw_d;
    logic [3:0] sr_q, sr_d;
    logic [11:0] crc_q, crc_d, par_q, par_d, crc_seen;
    logic bit_now;

    // Serial CRC of one block, first sent payload bit at the top.
    function automatic logic [11:0] blk_crc(input logic [11:0] c,
                                            input logic [63:0] d);
        for (int k = 63; k >= 0; k--)
            c = {c[10:0], 1'b0} ^ ((d[k] ^ c[11]) ? 12'h30f : 12'h000);
        return c;
    endfunction

    // Position is counted from reset on the link alone, so a sysref
    // restart in mid-stream would put this tracker out of step.
    always_comb
    begin
        bit_now = (blk_hdr == 2'h1);
        idx_d = idx_q;
        sw_d = sw_q;
        sr_d = sr_q;
        crc_d = crc_q;
        par_d = par_q;
        if (blk_valid)
        begin
            idx_d = idx_q + 5'h01;
            sw_d[idx_q] = bit_now;
            sr_d = {sr_q[2:0], bit_now};
            crc_d = blk_crc((idx_q == 5'h00) ? 12'h000 : crc_q, blk_pay);
            if (idx_q == 5'h1f)
                par_d = crc_d;
        end
        for (int i = 0; i < 12; i++)
            crc_seen[i] = sw_q[(11 - i) + (11 - i) / 3];
    end

    // Tracker registers; the shift history starts at ones so that no
    // false end pattern is seen straight after reset.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idx_q <= 5'h00;
            sw_q <= 32'h0;
            sr_q <= 4'hf;
            crc_q <= 12'h000;
            par_q <= 12'h000;
        end
        else
        begin
            idx_q <= idx_d;
            sw_q <= sw_d;
            sr_q <= sr_d;
            crc_q <= crc_d;
            par_q <= par_d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    property p_hdr_pair;
        blk_valid |-> blk_hdr[1] != blk_hdr[0];
    endproperty
    a_hdr_pair: assert property (p_hdr_pair)
        else $error("header pair not complementary");

    property p_fixed_one;
        blk_valid && idx_q inside {5'h03, 5'h07, 5'h0b, 5'h0f, 5'h13,
        5'h15, 5'h17} |-> blk_hdr == 2'h1;
    endproperty
    a_fixed_one: assert property (p_fixed_one)
        else $error("fixed one missing");

    property p_cmd_zero;
        blk_valid && idx_q inside {5'h10, 5'h11, 5'h12, 5'h14, 5'h18,
        5'h19, 5'h1a} |-> blk_hdr == 2'h2;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero)
        else $error("command bit not zero");

    property p_end_flag;
        blk_valid && idx_q == 5'h16 |-> blk_hdr == 2'h1;
    endproperty
    a_end_flag: assert property (p_end_flag)
        else $error("end flag not set");

    property p_end_pat;
        blk_valid && idx_q == 5'h1f |-> sw_q[30:27] == 4'h0 && bit_now;
    endproperty
    a_end_pat: assert property (p_end_pat)
        else $error("end pattern wrong");

    property p_unique;
        blk_valid && idx_q != 5'h1f |-> {sr_q, bit_now} != 5'h01;
    endproperty
    a_unique: assert property (p_unique)
        else $error("end pattern inside stream");

    property p_parity;
        blk_valid && idx_q == 5'h0f |-> crc_seen == par_q;
    endproperty
    a_parity: assert property (p_parity)
        else $error("carried parity wrong");

    property p_hold;
        !blk_valid |-> $stable(blk_hdr) && $stable(blk_pay);
    endproperty
    a_hold: assert property (p_hold)
        else $error("idle link changed");

    c_mb_end: cover property (blk_valid && idx_q == 5'h1f);
    c_burst: cover property (blk_valid [*8]);
    c_gap: cover property (blk_valid ##1 !blk_valid ##1 blk_valid);
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import shs_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic sref_a = 1'b0;
    logic sref_b = 1'b0;
    logic fec_b = 1'b0;
    logic pay_valid = 1'b0;
    logic [63:0] pay_data = 64'h0;
    logic mb_start, ov_a, lk_a, hb_a, me_a, ce_a, rr_a;
    logic lk_b, hb_b, me_b, ce_b, rr_b;
    logic [4:0] tx_idx;
    logic [4:0] rx_idx;
    logic slip_a;
    logic [11:0] par_tx;
    logic [11:0] cur_crc = 12'h000;
    logic [11:0] prev_crc = 12'h000;
    logic [11:0] crc_b = 12'h000;
    logic [63:0] od_a, exp_pay;
    logic [31:0] word_a;
    logic [1:0] eh;
    logic [63:0] q_tx[$], q_rx[$];
    int err_count = 0;
    int n_compared = 0;
    int n_seen = 0;
    int n_hb = 0;
    int n_me = 0;
    int n_ce = 0;
    int n_slip = 0;
    int n_bb = 0;
    int ce_at = 0;
    integer seed = 32'h66de;

    shs_link_if link_a ();
    shs_link_if link_b ();

    shs_tx shs_tx_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .sysref(sref_a), .pay_valid(pay_valid), .pay_data(pay_data),
        .mb_start(mb_start), .local_extended_group_clock_slip(slip_a), .blk_idx(tx_idx),
        .parity_sent(par_tx), .link(link_a));
    shs_rx shs_rx_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .sysref(sref_a), .fec_mode(1'b0), .link(link_a), .out_valid(ov_a),
        .out_data(od_a), .mb_locked(lk_a), .blk_idx(rx_idx), .hdr_bad(hb_a),
        .mb_err(me_a), .crc_err(ce_a), .realign_req(rr_a));
    // Second receiver, fed by the bench so that faults can be injected.
    shs_rx shs_rx_inst_b (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
        .sysref(sref_b), .fec_mode(fec_b), .link(link_b), .out_valid(),
        .out_data(), .mb_locked(lk_b), .blk_idx(), .hdr_bad(hb_b),
        .mb_err(me_b), .crc_err(ce_b), .realign_req(rr_b));
    shs_monitor shs_monitor_inst (.clock(clock), .sys_rst(sys_rst),
        .blk_valid(link_a.blk_valid), .blk_hdr(link_a.blk_hdr),
        .blk_pay(link_a.blk_pay));

    initial
        forever #2.5 clock = ~clock;

    function automatic logic [11:0] f_crc(input logic [11:0] c,
                                          input logic [63:0] d);
        for (int k = 63; k >= 0; k--)
            c = {c[10:0], 1'b0} ^ ((d[k] ^ c[11]) ? 12'h30f : 12'h000);
        return c;
    endfunction

    // Stream word: fixed ones, end flag, end pattern, parity in its slots.
    function automatic logic [31:0] f_word(input logic [11:0] p);
        logic [31:0] w;
        w = 32'h80e8_8888;
        for (int i = 0; i < 12; i++)
            w[(11 - i) + (11 - i) / 3] = p[i];
        return w;
    endfunction

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Freezes come only after two idle cycles, so no block is frozen
    // onto the link and counted twice.
    task automatic run_a(input int n);
        int sent;
        int idle;
        logic [31:0] r;
        logic [63:0] d;
        sent = 0;
        idle = 0;
        while (sent < n)
        begin
            @(posedge clock);
            r = $random(seed);
            clk_en <= !(idle >= 2 && r[3:0] == 4'h0);
            if (r[1:0] == 2'h0)
            begin
                pay_valid <= 1'b0;
                idle++;
            end
            else
            begin
                d = {$random(seed), $random(seed)};
                if (sent == 0)
                    d = 64'hffff_ffff_ffff_ffff;
                pay_valid <= 1'b1;
                pay_data <= d;
                q_tx.push_back(d);
                sent++;
                idle = 0;
            end
        end
        @(posedge clock);
        pay_valid <= 1'b0;
        clk_en <= 1'b1;
    endtask

    task automatic send_b(input logic [1:0] h, input logic [63:0] d);
        @(posedge clock);
        link_b.blk_valid <= 1'b1;
        link_b.blk_hdr <= h;
        link_b.blk_pay <= d;
    endtask

    task automatic idle_b(input int n);
        @(posedge clock);
        link_b.blk_valid <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    // One multiblock carrying parity p, with stream bits flipped by x.
    task automatic mb_b(input logic [11:0] p, input logic [31:0] x);
        logic [31:0] w;
        logic [63:0] d;
        w = f_word(p) ^ x;
        crc_b = 12'h000;
        for (int k = 0; k < 32; k++)
        begin
            d = {$random(seed), $random(seed)};
            crc_b = f_crc(crc_b, d);
            send_b(w[k] ? 2'h1 : 2'h2, d);
        end
    endtask

    // Score link a and receiver a against the bench model each cycle.
    always @(posedge clock)
    begin
        n_hb += (hb_b === 1'b1);
        n_me += (me_b === 1'b1);
        n_ce += (ce_b === 1'b1);
        n_slip += (slip_a === 1'b1);
        // Blocks seen on link b before the cycle that shows the CRC flag.
        if (ce_b === 1'b1)
            ce_at = n_bb;
        n_bb += (link_b.blk_valid === 1'b1);
        if (!sys_rst)
        begin
            chk((hb_a | me_a | ce_a | rr_a) === 1'b0, "rx a flag");
            if (ov_a === 1'b1)
                chk(od_a === q_rx.pop_front(), "rx a data");
            if (link_a.blk_valid === 1'b1)
            begin
                if (n_seen % 32 == 0)
                begin
                    prev_crc = cur_crc;
                    cur_crc = 12'h000;
                    word_a = f_word(prev_crc);
                    chk(par_tx === prev_crc, "parity");
                end
                exp_pay = q_tx.pop_front();
                eh = word_a[n_seen % 32] ? 2'h1 : 2'h2;
                chk(link_a.blk_pay === exp_pay, "tx data");
                chk(link_a.blk_hdr === eh, "tx header");
                chk(mb_start === (n_seen % 32 == 0), "mb start");
                cur_crc = f_crc(cur_crc, exp_pay);
                if (n_seen >= 32)
                    q_rx.push_back(exp_pay);
                n_seen++;
            end
        end
    end

    initial
    begin
        link_b.blk_valid = 1'b0;
        link_b.blk_hdr = 2'h2;
        link_b.blk_pay = 64'h0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        sref_a <= 1'b1;
        repeat (3) @(posedge clock);
        sref_a <= 1'b0;
        repeat (6) @(posedge clock);
        chk(tx_idx === 5'h00, "idx");
        run_a(96);
        repeat (4) @(posedge clock);
        chk(lk_a === 1'b1 && q_rx.size() == 0, "rx a lock");
        chk(tx_idx === 5'h00, "idx wrap");
        // A short group, then a strobe that must restart the transmit index.
        run_a(5);
        repeat (2) @(posedge clock);
        chk(tx_idx === 5'h05 && rx_idx === 5'h05, "idx part");
        sref_a <= 1'b1;
        repeat (3) @(posedge clock);
        sref_a <= 1'b0;
        repeat (6) @(posedge clock);
        chk(n_slip == 1 && tx_idx === 5'h00, "slip");
        mb_b(12'h000, 32'h0);
        mb_b(crc_b, 32'h0);
        chk(lk_b === 1'b1, "rx b lock");
        mb_b(crc_b ^ 12'h800, 32'h0);
        mb_b(crc_b, 32'h0);
        chk(n_ce == 1, "crc err");
        // Flag for group one's first bit, 46 blocks on, seen one later.
        chk(ce_at == 32 + 46 + 1, "crc latency");
        repeat (MB_ERR_LIM) mb_b(crc_b, 32'h0040_0000);
        idle_b(3);
        chk(n_me == MB_ERR_LIM && lk_b === 1'b0, "pilot");
        for (int i = 0; i < HDR_BAD_LIM; i++)
            send_b({2{i[0]}}, 64'h0);
        idle_b(3);
        chk(n_hb == HDR_BAD_LIM && rr_b === 1'b1, "bad hdr");
        sref_b <= 1'b1;
        repeat (3) @(posedge clock);
        sref_b <= 1'b0;
        repeat (6) @(posedge clock);
        chk(rr_b === 1'b0 && lk_b === 1'b0, "sysref");
        fec_b <= 1'b1;
        repeat (FEC_HITS - 1) mb_b(crc_b, 32'h0);
        idle_b(3);
        chk(lk_b === 1'b0, "fec early");
        mb_b(crc_b, 32'h0);
        idle_b(3);
        chk(lk_b === 1'b1, "fec lock");
        end_sim();
    end

    // Watchdog well beyond the few hundred cycles the run needs.
    initial
    begin
        #50000;
        err_count++;
        end_sim();
    end
endmodule
